// *** dds_regs.svh ***
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH
`define DDS_OFS_CTRL1 8'h00
`define DDS_OFS_CTRL2 8'h01
`define DDS_OFS_TUNE 8'h04
`define DDS_OFS_DEN 8'h05
`define DDS_OFS_NUM 8'h06
`define DDS_OFS_PROF0 8'h08
`define DDS_OFS_STATUS 8'h10
`define DDS_BIT_KEY_EN 8
`define DDS_BIT_SINE 16
`define DDS_BIT_MOD_EN 24
`define DDS_BIT_PORT_EN 22
`define DDS_BIT_PROF_EN 23
`define DDS_BIT_RAMP_EN 19
`define DDS_RAMP_DEST_LSB 20
`define DDS_UPD_DIV 16
`define DDS_CTRL1_RST 32'h00000000
`define DDS_CTRL2_RST 32'h00000000
`endif

// *** dds_pkg.sv ***
package dds_pkg;
	typedef enum logic [1:0] {
		DDS_DEST_FREQ = 2'h0,
		DDS_DEST_PHASE = 2'h1,
		DDS_DEST_AMP = 2'h2
	} dds_dest_e;
	typedef enum logic [2:0] {
		DDS_SRC_REG = 3'h1,
		DDS_SRC_PROF = 3'h2,
		DDS_SRC_PORT = 3'h4
	} dds_src_e;
endpackage

// *** dds_fifo.sv ***
`timescale 1ns/10ps
module dds_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
		$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic full;
	logic empty;
	assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
	assign empty = wr_ff == rd_ff;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_ff[rd_ff[AW-1:0]];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ff <= '0;
		end else if (ce && in_valid && !full) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
			wr_ff <= wr_ff + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_ff <= '0;
		end else if (ce && out_ready && !empty) begin
			rd_ff <= rd_ff + 1'b1;
		end
	end
	fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		(AW+1)'(wr_ff - rd_ff) <= DEPTH) else $error("fifo count past depth");
endmodule

// *** dds_core.sv ***
`timescale 1ns/10ps
`include "dds_regs.svh"
module dds_core #(
	parameter int NPROF = 8,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	// register port
	input wire logic REG_WE,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	// modulation pins
	input wire logic [2:0] PROFILE_SELECT_PINS,
	input wire logic [31:0] RAMP_VALUE,
	input wire logic [31:0] PORT_DATA,
	// sample output
	input wire logic DAC_READY,
	output logic DAC_VALID,
	output logic [11:0] DAC_DATA,
	output logic UPDATE_TICK
);
	import dds_pkg::*;
	if (NPROF != 8) begin : g_chk_prof
		$error("profile select pins serve exactly eight profiles");
	end
	if (FIFO_DEPTH < 2) begin : g_chk_fifo
		$error("fifo too shallow");
	end
	logic [31:0] ctrl1_ff, ctrl2_ff, tune_ff, den_ff, num_ff;
	logic [31:0] prof_ff [NPROF];
	logic [31:0] phase_ff, aux_ff;
	logic [3:0] div_ff;
	logic [2:0] ps_ff;
	logic [31:0] ramp_ff, port_ff;
	logic [31:0] freq_ff;
	logic [15:0] pofs_ff;
	logic [11:0] amp_ff;
	dds_src_e fsrc_ff;
	logic [11:0] sine_ff;
	logic sine_vld_ff;
	logic [11:0] dac_ff;
	logic dac_vld_ff;
	logic [31:0] rdata_ff;
	logic tick;
	logic mod_en, prof_en, port_en, ramp_en, key_en;
	dds_dest_e ramp_dest;
	logic fifo_ready, fifo_ovalid;
	logic [11:0] fifo_odata;
	assign mod_en = ctrl2_ff[`DDS_BIT_MOD_EN];
	assign prof_en = ctrl2_ff[`DDS_BIT_PROF_EN];
	assign port_en = ctrl2_ff[`DDS_BIT_PORT_EN];
	assign ramp_en = ctrl2_ff[`DDS_BIT_RAMP_EN];
	assign key_en = ctrl1_ff[`DDS_BIT_KEY_EN];
	assign ramp_dest = dds_dest_e'(ctrl2_ff[`DDS_RAMP_DEST_LSB +: 2]);
	assign tick = div_ff == 4'(`DDS_UPD_DIV - 1);
	// register writes
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ctrl1_ff <= `DDS_CTRL1_RST;
			ctrl2_ff <= `DDS_CTRL2_RST;
			tune_ff <= 32'h00000000;
			den_ff <= 32'h00000000;
			num_ff <= 32'h00000000;
		end else if (CE && REG_WE) begin
			case (REG_ADDR)
				`DDS_OFS_CTRL1: ctrl1_ff <= REG_WDATA;
				`DDS_OFS_CTRL2: ctrl2_ff <= REG_WDATA;
				`DDS_OFS_TUNE: tune_ff <= REG_WDATA;
				`DDS_OFS_DEN: den_ff <= REG_WDATA;
				`DDS_OFS_NUM: num_ff <= REG_WDATA;
				default: ;
			endcase
		end
	end
	// profile table: freq word per profile; phase/amp in the entry of profile xor 4
	genvar gi;
	generate
		for (gi = 0; gi < NPROF; gi++) begin : g_prof
			always_ff @(posedge MCLK) begin
				if (!RSTN) begin
					prof_ff[gi] <= 32'h00000000;
				end else if (CE && REG_WE && REG_ADDR == 8'(`DDS_OFS_PROF0 + gi)) begin
					prof_ff[gi] <= REG_WDATA;
				end
			end
		end
	endgenerate
	// readback
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			rdata_ff <= 32'h00000000;
		end else if (CE) begin
			case (REG_ADDR)
				`DDS_OFS_CTRL1: rdata_ff <= ctrl1_ff;
				`DDS_OFS_CTRL2: rdata_ff <= ctrl2_ff;
				`DDS_OFS_TUNE: rdata_ff <= tune_ff;
				`DDS_OFS_DEN: rdata_ff <= den_ff;
				`DDS_OFS_NUM: rdata_ff <= num_ff;
				`DDS_OFS_STATUS: rdata_ff <= phase_ff;
				default: begin
					if (REG_ADDR >= `DDS_OFS_PROF0 && REG_ADDR < 8'(`DDS_OFS_PROF0 + NPROF))
						rdata_ff <= prof_ff[3'(REG_ADDR - `DDS_OFS_PROF0)];
					else
						rdata_ff <= 32'h00000000;
				end
			endcase
		end
	end
	assign REG_RDATA = rdata_ff;
	// update divider
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			div_ff <= 4'h0;
		end else if (CE) begin
			div_ff <= div_ff + 4'h1;
		end
	end
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			UPDATE_TICK <= 1'b0;
		end else if (CE) begin
			UPDATE_TICK <= tick;
		end
	end
	// pin sampling on update tick only
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			ps_ff <= 3'h0;
			ramp_ff <= 32'h00000000;
			port_ff <= 32'h00000000;
		end else if (CE && tick) begin
			ps_ff <= PROFILE_SELECT_PINS;
			ramp_ff <= RAMP_VALUE;
			port_ff <= PORT_DATA;
		end
	end
	// priority selection, refreshed once per sixteen clocks
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			freq_ff <= 32'h00000000;
			pofs_ff <= 16'h0000;
			amp_ff <= 12'h000;
			fsrc_ff <= DDS_SRC_REG;
		end else if (CE && tick) begin
			if (mod_en) begin
				freq_ff <= tune_ff;
				fsrc_ff <= DDS_SRC_REG;
			end else if (ramp_en && ramp_dest == DDS_DEST_FREQ) begin
				freq_ff <= ramp_ff;
			end else if (prof_en) begin
				freq_ff <= prof_ff[ps_ff];
				fsrc_ff <= DDS_SRC_PROF;
			end else if (port_en) begin
				freq_ff <= port_ff;
				fsrc_ff <= DDS_SRC_PORT;
			end else begin
				freq_ff <= tune_ff;
				fsrc_ff <= DDS_SRC_REG;
			end
			if (!mod_en && ramp_en && ramp_dest == DDS_DEST_PHASE) begin
				pofs_ff <= ramp_ff[15:0];
			end else if (prof_en) begin
				pofs_ff <= prof_ff[ps_ff ^ 3'h4][15:0];
			end else if (port_en) begin
				pofs_ff <= port_ff[15:0];
			end
			if (!key_en) begin
				amp_ff <= 12'hFFF;
			end else if (!mod_en && ramp_en && ramp_dest == DDS_DEST_AMP) begin
				amp_ff <= ramp_ff[11:0];
			end else if (prof_en) begin
				amp_ff <= prof_ff[ps_ff ^ 3'h4][27:16];
			end else if (port_en) begin
				amp_ff <= port_ff[27:16];
			end
		end
	end
	// auxiliary accumulator with modulus B
	logic [32:0] aux_sum;
	logic aux_wrap;
	assign aux_sum = {1'b0, aux_ff} + {1'b0, num_ff};
	assign aux_wrap = mod_en && (aux_sum >= {1'b0, den_ff});
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			aux_ff <= 32'h00000000;
		end else if (CE) begin
			if (!mod_en)
				aux_ff <= 32'h00000000;
			else if (aux_wrap)
				aux_ff <= 32'(aux_sum - {1'b0, den_ff});
			else
				aux_ff <= aux_sum[31:0];
		end
	end
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			phase_ff <= 32'h00000000;
		end else if (CE) begin
			phase_ff <= phase_ff + freq_ff + {31'h0, aux_wrap};
		end
	end
	// angle to amplitude: parabola 4u(1-u) per half cycle, then scale
	logic [15:0] ang;
	logic [14:0] x;
	logic [29:0] sq;
	logic [11:0] mag;
	logic [11:0] smp;
	logic [23:0] scaled;
	always_comb begin
		ang = phase_ff[31:16] + pofs_ff;
		if (!ctrl1_ff[`DDS_BIT_SINE])
			ang = ang + 16'h4000;
		x = ang[14:0];
		sq = 30'(x) * 30'(16'h8000 - 16'(x));
		// exact peak needs one bit more; clamp it
		mag = sq[28] ? 12'h7FF : {1'b0, sq[27:17]};
		smp = ang[15] ? 12'h000 - mag : mag;
		scaled = {{12{smp[11]}}, smp} * {12'h000, amp_ff};
	end
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			sine_ff <= 12'h000;
			sine_vld_ff <= 1'b0;
		end else if (CE && fifo_ready) begin
			sine_ff <= scaled[23:12] ^ 12'h800;
			sine_vld_ff <= 1'b1;
		end
	end
	dds_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(MCLK),
		.rst_n(RSTN),
		.ce(CE),
		.in_valid(sine_vld_ff),
		.in_ready(fifo_ready),
		.in_data(sine_ff),
		.out_valid(fifo_ovalid),
		.out_ready(DAC_READY || !dac_vld_ff),
		.out_data(fifo_odata)
	);
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			dac_ff <= 12'h000;
			dac_vld_ff <= 1'b0;
		end else if (CE && (DAC_READY || !dac_vld_ff)) begin
			dac_ff <= fifo_odata;
			dac_vld_ff <= fifo_ovalid;
		end
	end
	assign DAC_DATA = dac_ff;
	assign DAC_VALID = dac_vld_ff;
	sequence wrap_s;
		CE && aux_wrap;
	endsequence
	wrap_lsb_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		wrap_s |=> phase_ff == $past(phase_ff) + $past(freq_ff) + 32'h1)
		else $error("wrap did not add lsb");
	aux_mod_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		mod_en && den_ff > 32'h1 && num_ff < den_ff |-> aux_ff < den_ff || $changed(den_ff))
		else $error("aux accumulator past modulus");
	mod_prio_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		CE && tick && mod_en |=> freq_ff == $past(tune_ff))
		else $error("modulus lost frequency");
	prof_port_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		CE && tick && !mod_en && !ramp_en && prof_en |=> fsrc_ff == DDS_SRC_PROF)
		else $error("port beat profile");
	upd_rate_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		$changed(pofs_ff) |-> $past(tick))
		else $error("update off tick");
	// enabled cycles since the last tick, kept apart from the divider
	logic [4:0] gap_ff;
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			gap_ff <= 5'h00;
		end else if (CE) begin
			gap_ff <= tick ? 5'h00 : gap_ff + 5'h01;
		end
	end
	tick_div_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		CE |-> tick == (gap_ff == 5'h0F))
		else $error("tick period wrong");
	norm_acc_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		CE && !mod_en |=> phase_ff == $past(phase_ff) + $past(freq_ff))
		else $error("phase step wrong");
	ramp_block_a: assert property (@(posedge MCLK) disable iff (!RSTN)
		CE && tick && mod_en && prof_en |=> pofs_ff == $past(prof_ff[ps_ff ^ 3'h4][15:0]))
		else $error("ramp drove phase in modulus");
endmodule

// *** dds_dac_model.sv ***
`timescale 1ns/10ps
module dds_dac_model (
	// clock
	input wire logic clk,
	// sample stream
	input wire logic valid,
	input wire logic [11:0] data,
	output logic ready,
	// control and tally
	input wire logic stall,
	input wire logic clr,
	input wire logic [11:0] exp_data,
	output int acc_cnt,
	output int err_cnt
);
	// sink may stall for as long as the bench asks
	assign ready = !stall;
	always_ff @(posedge clk) begin
		if (clr) begin
			acc_cnt <= 0;
			err_cnt <= 0;
		end else if (valid && ready) begin
			acc_cnt <= acc_cnt + 1;
			if (data !== exp_data) begin
				err_cnt <= err_cnt + 1;
			end
		end
	end
endmodule

// *** dds_core_modulus_priority_tb.sv ***
`timescale 1ns/10ps
module dds_core_modulus_priority_tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic we = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] port = 32'h00000000;
	logic [31:0] ramp = 32'h00000000;
	logic [2:0] pins = 3'h0;
	logic stall = 1'b0;
	logic clr = 1'b1;
	logic [11:0] exp_dac = 12'h800;
	logic [31:0] rdata;
	logic valid;
	logic ready;
	logic tick;
	logic [11:0] dac;
	int acc_cnt;
	int err_cnt;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;

	always #50 mclk = ~mclk;

	dds_core dds_core_i (.MCLK(mclk), .RSTN(rstn), .CE(1'b1), .REG_WE(we), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .PROFILE_SELECT_PINS(pins), .RAMP_VALUE(ramp),
		.PORT_DATA(port), .DAC_READY(ready), .DAC_VALID(valid), .DAC_DATA(dac),
		.UPDATE_TICK(tick));
	dds_dac_model dds_dac_model_i (.clk(mclk), .valid(valid), .data(dac), .ready(ready),
		.stall(stall), .clr(clr), .exp_data(exp_dac), .acc_cnt(acc_cnt), .err_cnt(err_cnt));

	task automatic end_of_test();
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		@(posedge mclk);
		#1 d = rdata;
	endtask

	// phase advance over n clocks, read from the accumulator index
	task automatic step(output logic [31:0] s, input int n);
		logic [31:0] p0;
		rd(8'h10, p0);
		repeat (n) @(posedge mclk);
		#1 s = rdata - p0;
	endtask

	task automatic settle();
		repeat (40) @(posedge mclk);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		rd(8'h10, d);
		chk(d, 32'h00000000);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		for (int i = 4; i < 7; i++) begin
			wr(8'(i), 32'hA5C3F00F ^ i);
			rd(8'(i), d);
			chk(d, 32'hA5C3F00F ^ i);
		end
		rd(8'h03, d);
		chk(d, 32'h00000000);
	endtask

	task automatic t_tick();
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 40) begin
			@(posedge mclk);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (tick !== 1'b1 && n < 40);
		chk(n, 16);
	endtask

	task automatic t_norm();
		logic [31:0] s;
		logic [31:0] w [2] = '{32'h01000001, 32'hC0000000};
		wr(8'h01, 32'h00000000);
		foreach (w[i]) begin
			wr(8'h04, w[i]);
			settle();
			step(s, 1);
			chk(s, w[i]);
		end
	endtask

	task automatic t_prio();
		logic [31:0] s;
		logic [31:0] c [3] = '{32'h00400000, 32'h00C00000, 32'h00C80000};
		logic [31:0] e [3] = '{32'h11111111, 32'h22222222, 32'h33333333};
		port <= 32'h11111111;
		ramp <= 32'h33333333;
		pins <= 3'h0;
		wr(8'h08, 32'h22222222);
		foreach (c[i]) begin
			wr(8'h01, c[i]);
			settle();
			step(s, 1);
			chk(s, e[i]);
		end
		wr(8'h01, 32'h00C00000);
		wr(8'h0B, 32'h44444444);
		pins <= 3'h3;
		settle();
		step(s, 1);
		chk(s, 32'h44444444);
	endtask

	task automatic t_mod();
		logic [31:0] s;
		logic [31:0] c [2] = '{32'h01D80000, 32'h01E80000};
		wr(8'h04, 32'h4CCCCCCC);
		wr(8'h05, 32'h00000005);
		wr(8'h06, 32'h00000004);
		wr(8'h01, 32'h01C80000);
		settle();
		step(s, 5);
		chk(s, 32'h80000000);
		step(s, 10);
		chk(s, 32'h00000000);
		// ramp aimed at phase, then amplitude, while modulus owns frequency
		foreach (c[i]) begin
			wr(8'h01, c[i]);
			settle();
			step(s, 5);
			chk(s, 32'h80000000);
		end
	endtask

	// one steady output level: flush, then count a window of samples
	task automatic dac_win(input logic [31:0] c1, input logic [11:0] e);
		clr <= 1'b1;
		exp_dac <= e;
		wr(8'h00, c1);
		settle();
		clr <= 1'b0;
		settle();
		chk(acc_cnt > 8, 1'b1);
		chk(err_cnt, 0);
	endtask

	task automatic t_dac();
		logic [31:0] p;
		pins <= 3'h0;
		wr(8'h01, 32'h00800000);
		wr(8'h08, 32'h00000000);
		settle();
		rd(8'h10, p);
		// phase is frozen; offset it to angle zero
		wr(8'h0C, {4'h0, 12'hFFF, 16'h0000 - p[31:16]});
		stall <= 1'b1;
		clr <= 1'b1;
		settle();
		clr <= 1'b0;
		settle();
		chk(valid, 1'b1);
		chk(acc_cnt, 0);
		stall <= 1'b0;
		dac_win(32'h00010100, 12'h800);
		dac_win(32'h00000100, 12'hFFE);
		wr(8'h0C, {4'h0, 12'h800, 16'h0000 - p[31:16]});
		dac_win(32'h00000100, 12'hBFF);
		dac_win(32'h00000000, 12'hFFE);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_regs();
		t_tick();
		t_norm();
		t_prio();
		t_mod();
		t_dac();
		end_of_test();
	end
endmodule
